// ---- rtl/bfdo_endpoint.sv ----
// Per-endpoint BFD processor: rx sampling, extraction, tx rewrite, continuity loss
// Notes on behaviour
// - Valid CC clears miss count, sets flag
// - Sampling enable copies remote fields per session
// - Field differences set per-session change flags
// - CC poll/final set session poll/final flags
// - Valid CV clears count, sets far poll/final
// - Interrupt only where enable bit set
// - Copy-all enables send every valid PDU
// - Next-good control extracts next valid PDU
// - Single shot chooses next or all
// - Param change extracts changed CC PDUs
// - Separate poll and final extract enables
// - Rx error enable extracts invalid PDUs
// - Valid to CC/CV queue, invalid to error
// - No tx pacing; only rewrite here
// - Tx session by MyDiscriminator match
// - Tx mismatch discards, flags, optionally extracts while rewrite enabled
// - Rewrite enable overwrites diag, state, multiplier
// - Selected scan timer increments readable miss count
// - Miss counter one bit wider than multiplier
// - Loss when count reaches twice session multiplier
// - Loss state readable, changes set flag
// - Rx session by YourDiscriminator, else near
//
// The APB register port and the address map were decided locally.
`include "bfdo_map.svh"

module bfdo_endpoint
	import bfdo_pkg::*;
#(
	parameter int SCAN_N = 8
) (
	// Clock and reset
	input  wire logic                         pclk,
	input  wire logic                         presetn,
	// APB slave
	input  wire logic                         psel,
	input  wire logic                         penable,
	input  wire logic                         pwrite,
	input  wire logic [`BFDO_ADDR_W-1:0]      paddr,
	input  wire logic [31:0]                  pwdata,
	output logic      [31:0]                  prdata,
	output logic                              pready,
	output logic                              pslverr,
	// Received PDU, one cycle strobe with fields
	input  wire logic                         rx_vld,
	input  wire logic                         rx_is_cv,
	input  wire logic                         rx_ok,
	input  wire logic [31:0]                  rx_your_discr,
	input  wire logic [`BFDO_DIAG_W-1:0]      rx_diag,
	input  wire logic [`BFDO_STATE_W-1:0]     rx_state,
	input  wire logic [`BFDO_DM_W-1:0]        rx_dm,
	input  wire logic                         rx_poll,
	input  wire logic                         rx_final,
	// Received PDU extraction verdict
	output logic                              rx_ext_vld,
	output bfdo_queue_t                       rx_ext_queue,
	// Transmitted PDU, one cycle strobe with fields
	input  wire logic                         tx_vld,
	input  wire logic                         tx_is_cv,
	input  wire logic [31:0]                  tx_my_discr,
	input  wire logic [`BFDO_DIAG_W-1:0]      tx_diag,
	input  wire logic [`BFDO_STATE_W-1:0]     tx_state,
	input  wire logic [`BFDO_DM_W-1:0]        tx_dm,
	// Transmitted PDU result
	output logic                              tx_out_vld,
	output logic                              tx_out_is_cv,
	output logic                              tx_discard,
	output logic                              tx_ext_err,
	output logic      [`BFDO_DIAG_W-1:0]      tx_out_diag,
	output logic      [`BFDO_STATE_W-1:0]     tx_out_state,
	output logic      [`BFDO_DM_W-1:0]        tx_out_dm,
	// Continuity scan timers from the shared controller
	input  wire logic [SCAN_N-1:0]            scan_tick,
	// Interrupt request and loss state
	output logic                              irq,
	output logic                              continuity_loss_state
);

	localparam int MW = `BFDO_DM_W + 1;

	typedef struct packed {
		logic [`BFDO_CFG_W-1:0] cfg;
		logic [31:0]            near_id;
		logic [31:0]            far_id;
		bfdo_info_t             near_loc;
		bfdo_info_t             far_loc;
		bfdo_info_t             near_rem;
		bfdo_info_t             far_rem;
		logic [`BFDO_EX_W-1:0]  ext;
		logic [`BFDO_FL_W-1:0]  flags;
		logic [`BFDO_FL_W-1:0]  int_ena;
		logic [MW-1:0]          miss;
		logic                   loss;
		logic [31:0]            prdata;
		logic                   pready;
		logic                   pslverr;
		logic                   rx_ext_vld;
		bfdo_queue_t            rx_ext_queue;
		logic                   tx_out_vld;
		logic                   tx_out_is_cv;
		logic                   tx_discard;
		logic                   tx_ext_err;
		bfdo_info_t             tx_info;
		logic                   irq;
	} bfdo_state_t;

	bfdo_state_t s_r;
	bfdo_state_t s_nxt;

	// Pack a session info word from separate fields
	function automatic bfdo_info_t mk_info(input logic [`BFDO_DIAG_W-1:0] d,
		input logic [`BFDO_STATE_W-1:0] st, input logic [`BFDO_DM_W-1:0] m);
		bfdo_info_t i;
		i.diag  = d;
		i.state = st;
		i.dm    = m;
		return i;
	endfunction

	// Difference bits for dm, state, diag between two info words
	function automatic logic [2:0] diff3(input bfdo_info_t a, input bfdo_info_t b);
		return {a.diag != b.diag, a.state != b.state, a.dm != b.dm};
	endfunction

	logic        wr_acc;
	logic        rd_acc;
	logic        rx_good;
	logic        rx_far;
	bfdo_info_t  rx_info;
	bfdo_info_t  rx_old;
	logic [2:0]  rx_chg;
	logic        crit_hit;
	logic        want_ext;
	logic        tx_near;
	logic        tx_far;
	logic        tick;
	logic [MW-1:0] thresh;
	logic        loss_now;
	logic [`BFDO_FL_W-1:0] hw_set;
	logic [`BFDO_FL_W-1:0] sw_clr;

	assign wr_acc  = psel & penable & pwrite;
	assign rd_acc  = psel & ~penable & ~pwrite;
	assign rx_info = mk_info(rx_diag, rx_state, rx_dm);

	always_comb begin
		s_nxt = s_r;
		// Rx session: CC goes far only in independent mode with discriminator checks on, CV whenever in independent mode
		rx_good = rx_vld & rx_ok;
		rx_far  = s_r.cfg[`BFDO_CFG_INDEP] & s_r.cfg[`BFDO_CFG_DISCR]
			& (rx_your_discr == s_r.far_id) & (rx_your_discr != s_r.near_id);
		rx_far  = rx_far | (rx_is_cv & s_r.cfg[`BFDO_CFG_INDEP]); // CV belongs to the far-end session
		rx_old  = rx_far ? s_r.far_rem : s_r.near_rem;
		rx_chg  = diff3(rx_info, rx_old);
		hw_set  = '0;
		// Rx event flags
		if (rx_good && !rx_is_cv) begin
			hw_set[`BFDO_FL_CC_RX] = 1'b1;
			if (rx_far) begin
				hw_set[`BFDO_FL_DG_F:`BFDO_FL_DM_F] = rx_chg;
				hw_set[`BFDO_FL_P_F] = rx_poll;
				hw_set[`BFDO_FL_F_F] = rx_final;
			end else begin
				hw_set[`BFDO_FL_DG_N:`BFDO_FL_DM_N] = rx_chg;
				hw_set[`BFDO_FL_P_N] = rx_poll;
				hw_set[`BFDO_FL_F_N] = rx_final;
			end
			// Remote field sampling
			if (s_r.cfg[`BFDO_CFG_SAMPLE]) begin
				if (rx_far)
					s_nxt.far_rem = rx_info;
				else
					s_nxt.near_rem = rx_info;
			end
		end
		if (rx_good && rx_is_cv) begin
			hw_set[`BFDO_FL_CV_RX] = 1'b1;
			hw_set[`BFDO_FL_P_F]   = rx_poll;
			hw_set[`BFDO_FL_F_F]   = rx_final;
		end

		// Rx extraction decision
		// Copy-all and next-good never consume the criterion enables
		crit_hit = (!rx_is_cv && s_r.ext[`BFDO_EX_PARAM] && (rx_chg != 3'h0))
			|| (s_r.ext[`BFDO_EX_POLL] && rx_poll) || (s_r.ext[`BFDO_EX_FINAL] && rx_final);
		want_ext = rx_is_cv ? (s_r.cfg[`BFDO_CFG_COPYCV] || s_r.ext[`BFDO_EX_NEXTCV])
			: (s_r.cfg[`BFDO_CFG_COPYCC] || s_r.ext[`BFDO_EX_NEXTCC]);
		want_ext = want_ext || crit_hit;
		s_nxt.rx_ext_vld   = 1'b0;
		s_nxt.rx_ext_queue = BFDO_Q_NONE;
		if (rx_good && want_ext) begin
			s_nxt.rx_ext_vld   = 1'b1;
			s_nxt.rx_ext_queue = rx_is_cv ? BFDO_Q_CV : BFDO_Q_CC;
			if (rx_is_cv)
				s_nxt.ext[`BFDO_EX_NEXTCV] = 1'b0;
			else
				s_nxt.ext[`BFDO_EX_NEXTCC] = 1'b0;
			if (crit_hit && s_r.ext[`BFDO_EX_ONCE]) begin
				s_nxt.ext[`BFDO_EX_PARAM] = 1'b0;
				s_nxt.ext[`BFDO_EX_POLL]  = 1'b0;
				s_nxt.ext[`BFDO_EX_FINAL] = 1'b0;
			end
		end
		if (rx_vld && !rx_ok && s_r.ext[`BFDO_EX_RXERR]) begin
			s_nxt.rx_ext_vld   = 1'b1;
			s_nxt.rx_ext_queue = BFDO_Q_ERR;
			if (s_r.ext[`BFDO_EX_ONCE])
				s_nxt.ext[`BFDO_EX_RXERR] = 1'b0;
		end

		// Tx session match and rewrite; no pacing, one result per input strobe
		// Mismatch is only judged while rewriting is on; otherwise PDUs pass as sent
		tx_near = tx_my_discr == s_r.near_id;
		tx_far  = s_r.cfg[`BFDO_CFG_INDEP] && !tx_near && (tx_my_discr == s_r.far_id);
		s_nxt.tx_out_vld   = tx_vld;
		s_nxt.tx_out_is_cv = tx_is_cv;
		s_nxt.tx_discard   = 1'b0;
		s_nxt.tx_ext_err   = 1'b0;
		s_nxt.tx_info      = mk_info(tx_diag, tx_state, tx_dm);
		if (tx_vld && s_r.cfg[`BFDO_CFG_TXUPD]) begin
			if (!tx_near && !tx_far) begin
				s_nxt.tx_discard = 1'b1;
				hw_set[`BFDO_FL_TX_MIS] = 1'b1;
				s_nxt.tx_ext_err = s_r.ext[`BFDO_EX_TXERR];
				if (s_r.ext[`BFDO_EX_TXERR] && s_r.ext[`BFDO_EX_ONCE])
					s_nxt.ext[`BFDO_EX_TXERR] = 1'b0;
			end else begin
				s_nxt.tx_info = tx_far ? s_r.far_loc : s_r.near_loc;
			end
		end

		// Miss counter and continuity loss; reception wins over a scan tick
		// The counter saturates so a long outage cannot wrap back to no loss
		tick   = |(scan_tick & (SCAN_N'(1) << s_r.cfg[`BFDO_CFG_SCAN_HI:`BFDO_CFG_SCAN_LO]));
		// Scans run at twice the PDU rate, so loss needs twice the multiplier
		thresh = {(s_r.cfg[`BFDO_CFG_INDEP] ? s_r.far_rem.dm : s_r.near_rem.dm), 1'b0};
		if (rx_good)
			s_nxt.miss = '0;
		else if (tick && s_r.miss != {MW{1'b1}})
			s_nxt.miss = s_r.miss + MW'(1);
		loss_now   = (thresh != '0) && (s_nxt.miss >= thresh);
		s_nxt.loss = loss_now;
		if (loss_now != s_r.loss)
			hw_set[`BFDO_FL_LOSS] = 1'b1;

		// APB register writes
		// A write lands at the access edge, where the master sees pready
		sw_clr = '0;
		if (wr_acc) begin
			unique case (paddr)
				`BFDO_OFS_CONFIG:   s_nxt.cfg      = pwdata[`BFDO_CFG_W-1:0];
				`BFDO_OFS_NEAR_ID:  s_nxt.near_id  = pwdata;
				`BFDO_OFS_FAR_ID:   s_nxt.far_id   = pwdata;
				`BFDO_OFS_NEAR_LOC: s_nxt.near_loc = pwdata[`BFDO_INFO_W-1:0];
				`BFDO_OFS_FAR_LOC:  s_nxt.far_loc  = pwdata[`BFDO_INFO_W-1:0];
				`BFDO_OFS_NEAR_REM: s_nxt.near_rem = pwdata[`BFDO_INFO_W-1:0];
				`BFDO_OFS_FAR_REM:  s_nxt.far_rem  = pwdata[`BFDO_INFO_W-1:0];
				`BFDO_OFS_EXTRACT:  s_nxt.ext      = pwdata[`BFDO_EX_W-1:0];
				`BFDO_OFS_FLAGS:    sw_clr         = pwdata[`BFDO_FL_W-1:0];
				`BFDO_OFS_INT_ENA:  s_nxt.int_ena  = pwdata[`BFDO_FL_W-1:0];
				default: ;
			endcase
		end
		s_nxt.flags = (s_r.flags & ~sw_clr) | hw_set;
		s_nxt.irq   = |(s_nxt.flags & s_nxt.int_ena);

		// APB read data is captured in setup so it stands in the access cycle
		s_nxt.pready  = psel & ~penable;
		s_nxt.pslverr = 1'b0;
		if (rd_acc) begin
			unique case (paddr)
				`BFDO_OFS_CONFIG:   s_nxt.prdata = 32'(s_r.cfg);
				`BFDO_OFS_NEAR_ID:  s_nxt.prdata = s_r.near_id;
				`BFDO_OFS_FAR_ID:   s_nxt.prdata = s_r.far_id;
				`BFDO_OFS_NEAR_LOC: s_nxt.prdata = 32'(s_r.near_loc);
				`BFDO_OFS_FAR_LOC:  s_nxt.prdata = 32'(s_r.far_loc);
				`BFDO_OFS_NEAR_REM: s_nxt.prdata = 32'(s_r.near_rem);
				`BFDO_OFS_FAR_REM:  s_nxt.prdata = 32'(s_r.far_rem);
				`BFDO_OFS_EXTRACT:  s_nxt.prdata = 32'(s_r.ext);
				`BFDO_OFS_FLAGS:    s_nxt.prdata = 32'(s_r.flags);
				`BFDO_OFS_INT_ENA:  s_nxt.prdata = 32'(s_r.int_ena);
				`BFDO_OFS_STATUS:   s_nxt.prdata = 32'({s_r.loss, s_r.miss[`BFDO_ST_LOSS-1:0]});
				default: begin
					s_nxt.prdata  = 32'h0;
					s_nxt.pslverr = 1'b1;
				end
			endcase
		end else if (psel && !penable) begin
			s_nxt.prdata = 32'h0;
		end
	end

	// Single state register; everything resets to zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end

	assign prdata                = s_r.prdata;
	assign pready                = s_r.pready;
	assign pslverr               = s_r.pslverr;
	assign rx_ext_vld            = s_r.rx_ext_vld;
	assign rx_ext_queue          = s_r.rx_ext_queue;
	assign tx_out_vld            = s_r.tx_out_vld;
	assign tx_out_is_cv          = s_r.tx_out_is_cv;
	assign tx_discard            = s_r.tx_discard;
	assign tx_ext_err            = s_r.tx_ext_err;
	assign tx_out_diag           = s_r.tx_info.diag;
	assign tx_out_state          = s_r.tx_info.state;
	assign tx_out_dm             = s_r.tx_info.dm;
	assign irq                   = s_r.irq;
	assign continuity_loss_state = s_r.loss;

	// Checks
	chk_cc_clear: assert property (@(posedge pclk) disable iff (!presetn)
		rx_vld && rx_ok |=> s_r.miss == '0)
		else $error("miss count not cleared");
	chk_irq_gate: assert property (@(posedge pclk) disable iff (!presetn)
		irq == |(s_r.flags & s_r.int_ena))
		else $error("irq not gated by enables");
	chk_loss_flag: assert property (@(posedge pclk) disable iff (!presetn)
		$changed(continuity_loss_state) |-> s_r.flags[`BFDO_FL_LOSS])
		else $error("loss change not flagged");
	chk_tx_mis: assert property (@(posedge pclk) disable iff (!presetn)
		tx_discard |-> s_r.flags[`BFDO_FL_TX_MIS] && tx_out_vld)
		else $error("tx discard without flag");
	chk_err_queue: assert property (@(posedge pclk) disable iff (!presetn)
		rx_vld && !rx_ok && s_r.ext[`BFDO_EX_RXERR] |=> rx_ext_vld && rx_ext_queue == BFDO_Q_ERR)
		else $error("invalid PDU not to error queue");
	chk_cv_far_poll: assert property (@(posedge pclk) disable iff (!presetn)
		rx_vld && rx_ok && rx_is_cv && rx_poll |=> s_r.flags[`BFDO_FL_P_F])
		else $error("cv poll flag lost");
	chk_copy_cc: assert property (@(posedge pclk) disable iff (!presetn)
		rx_vld && rx_ok && !rx_is_cv && s_r.cfg[`BFDO_CFG_COPYCC] |=> rx_ext_vld && rx_ext_queue == BFDO_Q_CC)
		else $error("cc copy missing");
	chk_loss_thresh: assert property (@(posedge pclk) disable iff (!presetn)
		continuity_loss_state |-> s_r.miss != '0)
		else $error("loss with zero count");
	chk_flag_sticky: assert property (@(posedge pclk) disable iff (!presetn)
		$fell(s_r.flags[`BFDO_FL_CC_RX]) |-> $past(wr_acc) && $past(paddr) == `BFDO_OFS_FLAGS)
		else $error("flag fell without write");
	chk_cv_queue: assert property (@(posedge pclk) disable iff (!presetn)
		rx_vld && rx_ok && rx_is_cv && s_r.cfg[`BFDO_CFG_COPYCV] |=> rx_ext_vld && rx_ext_queue == BFDO_Q_CV)
		else $error("cv copy missing");
	chk_next_spent: assert property (@(posedge pclk) disable iff (!presetn)
		rx_vld && rx_ok && !rx_is_cv && s_r.ext[`BFDO_EX_NEXTCC] && !wr_acc
		|=> !s_r.ext[`BFDO_EX_NEXTCC])
		else $error("next good cc not spent");
	chk_once_spent: assert property (@(posedge pclk) disable iff (!presetn)
		rx_vld && !rx_ok && s_r.ext[`BFDO_EX_RXERR] && s_r.ext[`BFDO_EX_ONCE] && !wr_acc
		|=> !s_r.ext[`BFDO_EX_RXERR])
		else $error("single shot rx error not spent");
	chk_tx_rewrite: assert property (@(posedge pclk) disable iff (!presetn)
		tx_vld && s_r.cfg[`BFDO_CFG_TXUPD] && tx_my_discr == s_r.near_id
		|=> !tx_discard && tx_out_dm == $past(s_r.near_loc.dm))
		else $error("near rewrite wrong");
	chk_tx_pass: assert property (@(posedge pclk) disable iff (!presetn)
		tx_vld && !s_r.cfg[`BFDO_CFG_TXUPD] |=> tx_out_vld && !tx_discard && tx_out_dm == $past(tx_dm))
		else $error("tx not passed through");
	chk_miss_tick: assert property (@(posedge pclk) disable iff (!presetn)
		!(rx_vld && rx_ok) && tick && s_r.miss != {MW{1'b1}} |=> s_r.miss == MW'($past(s_r.miss) + 1'b1))
		else $error("miss count not stepped");
	chk_set_wins: assert property (@(posedge pclk) disable iff (!presetn)
		rx_vld && rx_ok && !rx_is_cv |=> s_r.flags[`BFDO_FL_CC_RX])
		else $error("cc flag lost to clear");
	chk_near_default: assert property (@(posedge pclk) disable iff (!presetn)
		rx_vld && rx_ok && !rx_is_cv && !s_r.cfg[`BFDO_CFG_DISCR] && rx_poll |=> s_r.flags[`BFDO_FL_P_N])
		else $error("cc not given to near session");

	cov_loss: cover property (@(posedge pclk) $rose(continuity_loss_state));
	cov_txmis: cover property (@(posedge pclk) tx_discard);
	cov_cv_ext: cover property (@(posedge pclk) rx_ext_vld && rx_ext_queue == BFDO_Q_CV);
	cov_far_cc: cover property (@(posedge pclk) rx_vld && rx_ok && !rx_is_cv && rx_far);
	cov_rewrite: cover property (@(posedge pclk) tx_out_vld && !tx_discard && s_r.cfg[`BFDO_CFG_TXUPD]);

endmodule // bfdo_endpoint

// ---- rtl/bfdo_map.svh ----
// Register offsets, field positions and widths for the BFD endpoint block
`ifndef BFDO_MAP_SVH
`define BFDO_MAP_SVH
`define BFDO_ADDR_W        8
`define BFDO_OFS_CONFIG    8'h00
`define BFDO_OFS_NEAR_ID   8'h04
`define BFDO_OFS_FAR_ID    8'h08
`define BFDO_OFS_NEAR_LOC  8'h0c
`define BFDO_OFS_FAR_LOC   8'h10
`define BFDO_OFS_NEAR_REM  8'h14
`define BFDO_OFS_FAR_REM   8'h18
`define BFDO_OFS_EXTRACT   8'h1c
`define BFDO_OFS_FLAGS     8'h20
`define BFDO_OFS_INT_ENA   8'h24
`define BFDO_OFS_STATUS    8'h28
// Config bits
`define BFDO_CFG_INDEP     0
`define BFDO_CFG_DISCR     1
`define BFDO_CFG_SAMPLE    2
`define BFDO_CFG_TXUPD     3
`define BFDO_CFG_COPYCC    4
`define BFDO_CFG_COPYCV    5
`define BFDO_CFG_SCAN_LO   6
`define BFDO_CFG_SCAN_HI   8
`define BFDO_CFG_W         9
// Extract bits
`define BFDO_EX_NEXTCC     0
`define BFDO_EX_NEXTCV     1
`define BFDO_EX_ONCE       2
`define BFDO_EX_PARAM      3
`define BFDO_EX_POLL       4
`define BFDO_EX_FINAL      5
`define BFDO_EX_RXERR      6
`define BFDO_EX_TXERR      7
`define BFDO_EX_W          8
// Event flag bits
`define BFDO_FL_DM_N       0
`define BFDO_FL_ST_N       1
`define BFDO_FL_DG_N       2
`define BFDO_FL_P_N        3
`define BFDO_FL_F_N        4
`define BFDO_FL_DM_F       5
`define BFDO_FL_ST_F       6
`define BFDO_FL_DG_F       7
`define BFDO_FL_P_F        8
`define BFDO_FL_F_F        9
`define BFDO_FL_LOSS       10
`define BFDO_FL_CC_RX      11
`define BFDO_FL_CV_RX      12
`define BFDO_FL_TX_MIS     13
`define BFDO_FL_W          14
// Status bits
`define BFDO_ST_LOSS       8
// Session info packing: diag[4:0], state[6:5], dm[14:7]
`define BFDO_DIAG_W        5
`define BFDO_STATE_W       2
`define BFDO_DM_W          8
`define BFDO_INFO_W        15
`endif

// ---- rtl/bfdo_pkg.sv ----
// Types shared by the BFD endpoint block
package bfdo_pkg;
	`include "bfdo_map.svh"
	typedef struct packed {
		logic [`BFDO_DM_W-1:0]    dm;
		logic [`BFDO_STATE_W-1:0] state;
		logic [`BFDO_DIAG_W-1:0]  diag;
	} bfdo_info_t;
	typedef enum logic [1:0] {
		BFDO_Q_NONE,
		BFDO_Q_CC,
		BFDO_Q_CV,
		BFDO_Q_ERR
	} bfdo_queue_t;
endpackage

// ---- test/bfdo_peer.sv ----
// Remote BFD peer model: hands received PDUs to the endpoint, one per strobe
module bfdo_peer (
	// Clock
	input  wire logic        pclk,
	// Received PDU toward the endpoint
	output logic             rx_vld,
	output logic             rx_is_cv,
	output logic             rx_ok,
	output logic [31:0]      rx_your_discr,
	output logic [4:0]       rx_diag,
	output logic [1:0]       rx_state,
	output logic [7:0]       rx_dm,
	output logic             rx_poll,
	output logic             rx_final
);
	timeunit 1ns;
	timeprecision 1ps;

	// Idle link: no strobe, fields hold junk
	initial begin
		rx_vld = 1'b0;
		{rx_is_cv, rx_ok, rx_your_discr, rx_diag, rx_state, rx_dm, rx_poll, rx_final} = '1;
	end

	// One PDU per call; pacing is ours, the endpoint never asks for one
	task automatic send(input logic cv, ok, input logic [31:0] d, input logic [4:0] dg,
		input logic [1:0] st, input logic [7:0] dm, input logic p, f);
		@(posedge pclk);
		rx_vld <= 1'b1;
		{rx_is_cv, rx_ok, rx_your_discr, rx_diag, rx_state, rx_dm, rx_poll, rx_final} <= {cv, ok, d, dg, st, dm, p, f};
		@(posedge pclk);
		rx_vld <= 1'b0;
		// Released fields are inverted so stale values cannot pass as good
		{rx_is_cv, rx_ok, rx_your_discr, rx_diag, rx_state, rx_dm, rx_poll, rx_final} <= ~{cv, ok, d, dg, st, dm, p, f};
		#1;
	endtask
endmodule // bfdo_peer

// ---- test/tb.sv ----
// Self-checking bench for the BFD endpoint processor
`include "bfdo_map.svh"
module tb import bfdo_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ps;

	logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00, scan_tick = 8'h00, rx_dm, tx_dm = 8'h00, tx_out_dm;
	logic [31:0] pwdata = 32'h0, prdata, rx_your_discr, tx_my_discr = 32'h0, rd;
	logic        pready, pslverr, er, rx_vld, rx_is_cv, rx_ok, rx_poll, rx_final, rx_ext_vld;
	logic [4:0]  rx_diag, tx_diag = 5'h00, tx_out_diag;
	logic [1:0]  rx_state, tx_state = 2'h0, tx_out_state;
	logic        tx_vld = 1'b0, tx_is_cv = 1'b0, tx_out_vld, tx_out_is_cv, tx_discard, tx_ext_err;
	logic        irq, continuity_loss_state;
	bfdo_queue_t rx_ext_queue;
	int          err_count = 0, tests_run = 0;

	always #2.5 pclk = ~pclk;

	bfdo_endpoint #(.SCAN_N(8)) u_bfdo_endpoint (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .rx_vld(rx_vld), .rx_is_cv(rx_is_cv), .rx_ok(rx_ok),
		.rx_your_discr(rx_your_discr), .rx_diag(rx_diag), .rx_state(rx_state), .rx_dm(rx_dm),
		.rx_poll(rx_poll), .rx_final(rx_final), .rx_ext_vld(rx_ext_vld), .rx_ext_queue(rx_ext_queue),
		.tx_vld(tx_vld), .tx_is_cv(tx_is_cv), .tx_my_discr(tx_my_discr), .tx_diag(tx_diag),
		.tx_state(tx_state), .tx_dm(tx_dm), .tx_out_vld(tx_out_vld), .tx_out_is_cv(tx_out_is_cv),
		.tx_discard(tx_discard), .tx_ext_err(tx_ext_err), .tx_out_diag(tx_out_diag),
		.tx_out_state(tx_out_state), .tx_out_dm(tx_out_dm), .scan_tick(scan_tick), .irq(irq),
		.continuity_loss_state(continuity_loss_state));

	bfdo_peer u_bfdo_peer (.pclk(pclk), .rx_vld(rx_vld), .rx_is_cv(rx_is_cv), .rx_ok(rx_ok),
		.rx_your_discr(rx_your_discr), .rx_diag(rx_diag), .rx_state(rx_state), .rx_dm(rx_dm),
		.rx_poll(rx_poll), .rx_final(rx_final));

	task automatic chk(input logic [31:0] seen, exp, input string m);
		tests_run++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED t=%0t %s: seen %h expected %h", $time, m, seen, exp);
		end
	endtask

	// APB master: request held until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) chk(32'h0, 32'h1, "apb no ready");
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string m);
		apb(1'b0, a, 32'h0);
		chk(rd, e, m);
	endtask

	task automatic rxc(input logic v, input bfdo_queue_t q, input string m);
		chk({29'h0, rx_ext_vld, rx_ext_queue}, {29'h0, v, q}, m);
	endtask

	// Outgoing CV PDU with diag 1, state 0, multiplier 9
	task automatic tx_go(input logic [31:0] d);
		@(posedge pclk);
		tx_vld <= 1'b1;
		{tx_is_cv, tx_my_discr, tx_diag, tx_state, tx_dm} <= {1'b1, d, 5'h01, 2'h0, 8'h09};
		@(posedge pclk);
		tx_vld <= 1'b0;
		{tx_is_cv, tx_my_discr, tx_diag, tx_state, tx_dm} <= ~{1'b1, d, 5'h01, 2'h0, 8'h09};
		#1;
	endtask

	task automatic txc(input logic [31:0] d, input logic [17:0] e, input string m);
		tx_go(d);
		chk({14'h0, tx_out_vld, tx_out_is_cv, tx_discard, tx_out_diag, tx_out_state, tx_out_dm}, {14'h0, e}, m);
	endtask

	task automatic tick(input int i);
		@(posedge pclk);
		scan_tick <= 8'h01 << i;
		@(posedge pclk);
		scan_tick <= 8'h00;
		#1;
	endtask

	task automatic t_regs();
		rdc(`BFDO_OFS_CONFIG, 32'h0, "config reset");
		rdc(`BFDO_OFS_STATUS, 32'h0, "status reset");
		apb(1'b0, 8'h40, 32'h0);
		chk({er, rd[30:0]}, 32'h80000000, "unmapped read");
		$display("test regs done");
	endtask

	task automatic t_rx_cc();
		wr(`BFDO_OFS_NEAR_REM, 32'h180);
		wr(`BFDO_OFS_CONFIG, 32'h14);
		u_bfdo_peer.send(1'b0, 1'b1, 32'h0, 5'h02, 2'h1, 8'h05, 1'b1, 1'b0);
		rxc(1'b1, BFDO_Q_CC, "copy cc");
		rdc(`BFDO_OFS_NEAR_REM, 32'h2a2, "sampled");
		rdc(`BFDO_OFS_FLAGS, 32'h80f, "change flags");
		chk(rd & 32'h808, 32'h808, "cc and poll");
		wr(`BFDO_OFS_FLAGS, 32'h3fff);
		rdc(`BFDO_OFS_FLAGS, 32'h0, "w1c");
		u_bfdo_peer.send(1'b0, 1'b1, 32'h0, 5'h02, 2'h1, 8'h05, 1'b0, 1'b0);
		rxc(1'b1, BFDO_Q_CC, "copy cc again");
		rdc(`BFDO_OFS_FLAGS, 32'h800, "no change");
		$display("test rx_cc done");
	endtask

	task automatic t_cv_irq();
		wr(`BFDO_OFS_FLAGS, 32'h3fff);
		wr(`BFDO_OFS_FAR_ID, 32'h22);
		wr(`BFDO_OFS_CONFIG, 32'h27);
		u_bfdo_peer.send(1'b1, 1'b1, 32'h22, 5'h00, 2'h0, 8'h00, 1'b0, 1'b1);
		rxc(1'b1, BFDO_Q_CV, "copy cv");
		rdc(`BFDO_OFS_FLAGS, 32'h1200, "cv flags");
		wr(`BFDO_OFS_INT_ENA, 32'h200);
		rdc(`BFDO_OFS_INT_ENA, 32'h200, "int ena");
		chk({31'h0, irq}, 32'h1, "irq on");
		wr(`BFDO_OFS_INT_ENA, 32'h1);
		rdc(`BFDO_OFS_INT_ENA, 32'h1, "int ena");
		chk({31'h0, irq}, 32'h0, "irq masked");
		wr(`BFDO_OFS_FLAGS, 32'h3fff);
		u_bfdo_peer.send(1'b0, 1'b1, 32'h22, 5'h01, 2'h0, 8'h03, 1'b0, 1'b0);
		rdc(`BFDO_OFS_FLAGS, 32'h8a0, "far cc flags");
		rdc(`BFDO_OFS_FAR_REM, 32'h181, "far sampled");
		$display("test cv_irq done");
	endtask

	task automatic t_loss();
		wr(`BFDO_OFS_CONFIG, 32'h80);
		wr(`BFDO_OFS_NEAR_REM, 32'h180);
		wr(`BFDO_OFS_FLAGS, 32'h3fff);
		tick(1);
		repeat (5) tick(2);
		chk({31'h0, continuity_loss_state}, 32'h0, "loss early");
		tick(2);
		chk({31'h0, continuity_loss_state}, 32'h1, "loss at twice dm");
		rdc(`BFDO_OFS_STATUS, 32'h106, "miss count");
		rdc(`BFDO_OFS_FLAGS, 32'h400, "loss change");
		u_bfdo_peer.send(1'b0, 1'b1, 32'h0, 5'h00, 2'h0, 8'h03, 1'b0, 1'b0);
		chk({31'h0, continuity_loss_state}, 32'h0, "loss gone");
		rdc(`BFDO_OFS_STATUS, 32'h0, "miss cleared");
		$display("test loss done");
	endtask

	task automatic t_tx();
		wr(`BFDO_OFS_CONFIG, 32'h08);
		wr(`BFDO_OFS_NEAR_ID, 32'h11);
		wr(`BFDO_OFS_NEAR_LOC, 32'h1e4);
		wr(`BFDO_OFS_FAR_LOC, 32'h0ca);
		wr(`BFDO_OFS_EXTRACT, 32'h84);
		wr(`BFDO_OFS_FLAGS, 32'h3fff);
		txc(32'h11, {3'b110, 5'h04, 2'h3, 8'h03}, "near rewrite");
		tx_go(32'h55);
		chk({30'h0, tx_discard, tx_ext_err}, 32'h3, "mismatch");
		tx_go(32'h55);
		chk({30'h0, tx_discard, tx_ext_err}, 32'h2, "single shot");
		rdc(`BFDO_OFS_EXTRACT, 32'h04, "txerr spent");
		rdc(`BFDO_OFS_FLAGS, 32'h2000, "tx flag");
		wr(`BFDO_OFS_CONFIG, 32'h09);
		txc(32'h22, {3'b110, 5'h0a, 2'h2, 8'h01}, "far rewrite");
		wr(`BFDO_OFS_CONFIG, 32'h00);
		txc(32'h55, {3'b110, 5'h01, 2'h0, 8'h09}, "pass through");
		$display("test tx done");
	endtask

	task automatic t_extract();
		wr(`BFDO_OFS_EXTRACT, 32'h40);
		u_bfdo_peer.send(1'b0, 1'b0, 32'h0, 5'h00, 2'h0, 8'h03, 1'b0, 1'b0);
		rxc(1'b1, BFDO_Q_ERR, "rx err cc");
		u_bfdo_peer.send(1'b1, 1'b0, 32'h0, 5'h00, 2'h0, 8'h03, 1'b0, 1'b0);
		rxc(1'b1, BFDO_Q_ERR, "rx err cv");
		wr(`BFDO_OFS_EXTRACT, 32'h01);
		u_bfdo_peer.send(1'b0, 1'b1, 32'h0, 5'h00, 2'h0, 8'h03, 1'b0, 1'b0);
		rxc(1'b1, BFDO_Q_CC, "next good");
		u_bfdo_peer.send(1'b0, 1'b1, 32'h0, 5'h00, 2'h0, 8'h03, 1'b0, 1'b0);
		rxc(1'b0, BFDO_Q_NONE, "next spent");
		wr(`BFDO_OFS_EXTRACT, 32'h14);
		u_bfdo_peer.send(1'b1, 1'b1, 32'h0, 5'h00, 2'h0, 8'h03, 1'b1, 1'b0);
		rxc(1'b1, BFDO_Q_CV, "poll");
		u_bfdo_peer.send(1'b1, 1'b1, 32'h0, 5'h00, 2'h0, 8'h03, 1'b1, 1'b0);
		rxc(1'b0, BFDO_Q_NONE, "poll once");
		wr(`BFDO_OFS_EXTRACT, 32'h08);
		u_bfdo_peer.send(1'b0, 1'b1, 32'h0, 5'h00, 2'h0, 8'h04, 1'b0, 1'b0);
		rxc(1'b1, BFDO_Q_CC, "param change");
		$display("test extract done");
	endtask

	task automatic test_done();
		$display("checks %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask

	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_rx_cc();
		t_cv_irq();
		t_loss();
		t_tx();
		t_extract();
		test_done();
	end

	// Whole run needs well under 2000 cycles
	initial begin
		#50000;
		err_count++;
		test_done();
	end
endmodule // tb
